// ---- housekeeping_model.sv ----
`timescale 1ns/100ps
module housekeeping_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Handshake
	input wire logic prepare_req,
	input wire logic [7:0] delay,
	output logic prepare_done
);
	logic [7:0] busy_r;
	always_ff @(posedge aclk) busy_r <= (!aresetn || !prepare_req) ? 8'h00 : busy_r + {7'h00, busy_r != 8'hFF};
	// Zero delay is the plain loopback
	assign prepare_done = prepare_req && busy_r >= delay;
endmodule // housekeeping_model

// ---- sleep_entry_sequencer.sv ----
`timescale 1ns/100ps
// What this block does
// - Sequencer is a fully encoded three-bit state machine steering gating, macro, housekeeping.
// - Watch sleep request pin; confirm it persists for a qualification interval first.
// - After qualification raise active-high prepare request, synchronous to the system clock.
// - Sleep-active rises only after housekeeping, clock gating and mode entry completed.
// - Sleep-active holds throughout sleep, released only after request pin deasserts.
// - Function is state machine, clock gating filter stage and low-power entry macro.
// - Held output pad is weakly pulled to its last registered value, ignoring pull setting.
// - Held input pad freezes core-side value at last pad value before entry.
// - Unheld input pad gives the core constant high throughout sleep.
// - Pull enabled without hold presents configured pull-up or pull-down, inputs and outputs.
// - Neither hold nor pull: pad tristated in sleep; floating inputs are harmless.
// - Bidirectional pad follows input rules when enable low, output rules when high.
// - Hold, pull direction and tristate are chosen independently per pin.
module sleep_entry_sequencer
	import sleep_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [sleep_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [sleep_seq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sleep request pin, asynchronous
	input wire logic sleep_request_pin,
	// Housekeeping handshake with user logic
	output logic prepare_req,
	input wire logic prepare_done,
	// Power control
	output logic clock_gate_en,
	output logic low_power_entry_macro_en,
	output logic sleep_active,
	// Core side of the pads
	input wire logic [sleep_seq_pkg::NUM_PADS-1:0] core_out,
	input wire logic [sleep_seq_pkg::NUM_PADS-1:0] core_oe,
	output logic [sleep_seq_pkg::NUM_PADS-1:0] core_in,
	// Pad side
	input wire logic [sleep_seq_pkg::NUM_PADS-1:0] pad_in,
	output sleep_seq_pkg::pad_drive_type pad_drive
);
	import sleep_seq_pkg::*;

	typedef struct packed {
		// Request pin synchroniser and filtered level
		logic pin_s1;
		logic pin_s2;
		logic pin_s3;
		logic pin_level;
		// Pad input synchroniser and filtered level
		logic [NUM_PADS-1:0] pad_s1;
		logic [NUM_PADS-1:0] pad_s2;
		logic [NUM_PADS-1:0] pad_s3;
		logic [NUM_PADS-1:0] pad_level;
		// Sequencer
		seq_state_type state;
		logic [CNT_W-1:0] cnt;
		logic prepare_req;
		logic clock_gated;
		logic macro_en;
		logic sleep_active;
		// Values captured at entry
		logic [NUM_PADS-1:0] held_in;
		logic [NUM_PADS-1:0] held_out;
		logic [NUM_PADS-1:0] held_oe;
		// Configuration and pad drive
		pad_cfg_type cfg;
		pad_drive_type drive;
		logic [NUM_PADS-1:0] core_in;
		// Bus slave
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	localparam state_type STATE_RESET = '{state: ST_IDLE, cfg: PAD_CFG_RESET, default: '0};

	state_type st_r;
	state_type st_nxt;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Wait counters: step by one, and finish on the stage's last value
	function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] val);
		return val + CNT_ONE;
	endfunction

	function automatic logic cnt_reached(input logic [CNT_W-1:0] val, input logic [CNT_W-1:0] last);
		return val == last;
	endfunction

	// Register decode shared by the write and read channels
	function automatic logic is_cfg(input logic [ADDR_W-1:0] addr);
		return addr == PAD_CFG_ADDR;
	endfunction

	function automatic logic is_status(input logic [ADDR_W-1:0] addr);
		return addr == STATUS_ADDR;
	endfunction

	always_comb begin
		status_type stat;
		st_nxt = st_r;
		stat = '0;

		// Three-stage synchronisers; a change counts once stages two and three agree
		st_nxt.pin_s1 = sleep_request_pin;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_s3 = st_r.pin_s2;
		if (st_r.pin_s2 == st_r.pin_s3) begin
			st_nxt.pin_level = st_r.pin_s3;
		end
		st_nxt.pad_s1 = pad_in;
		st_nxt.pad_s2 = st_r.pad_s1;
		st_nxt.pad_s3 = st_r.pad_s2;
		for (int i = 0; i < NUM_PADS; i++) begin
			if (st_r.pad_s2[i] == st_r.pad_s3[i]) begin
				st_nxt.pad_level[i] = st_r.pad_s3[i];
			end
		end

		// Sequencer
		case (st_r.state)
			ST_IDLE: begin
				if (st_r.pin_level) begin
					st_nxt.state = ST_QUALIFY;
					st_nxt.cnt = CNT_ZERO;
				end
			end
			ST_QUALIFY: begin
				if (!st_r.pin_level) begin
					st_nxt.state = ST_IDLE;
				end else if (cnt_reached(st_r.cnt, QUALIFY_LAST)) begin
					st_nxt.state = ST_HOUSEKEEP;
					st_nxt.prepare_req = 1'b1;
				end else begin
					st_nxt.cnt = cnt_step(st_r.cnt);
				end
			end
			ST_HOUSEKEEP: begin
				// Request withdrawn during housekeeping: abandon the entry
				if (!st_r.pin_level) begin
					st_nxt.state = ST_IDLE;
					st_nxt.prepare_req = 1'b0;
				end else if (prepare_done) begin
					st_nxt.state = ST_GATE;
					st_nxt.prepare_req = 1'b0;
					st_nxt.clock_gated = 1'b1;
					st_nxt.cnt = CNT_ZERO;
				end
			end
			ST_GATE: begin
				// Filter stage: let gated clocks settle before the macro
				if (cnt_reached(st_r.cnt, SETTLE_LAST)) begin
					st_nxt.state = ST_ENTER;
					st_nxt.macro_en = 1'b1;
				end else begin
					st_nxt.cnt = cnt_step(st_r.cnt);
				end
			end
			ST_ENTER: begin
				st_nxt.state = ST_ASLEEP;
				st_nxt.sleep_active = 1'b1;
				// Capture the pads as they stood in the last awake cycle
				st_nxt.held_in = st_r.pad_level;
				st_nxt.held_out = st_r.drive.out;
				st_nxt.held_oe = st_r.drive.oe;
			end
			ST_ASLEEP: begin
				if (!st_r.pin_level) begin
					st_nxt.state = ST_RELEASE;
					st_nxt.macro_en = 1'b0;
					st_nxt.cnt = CNT_ZERO;
				end
			end
			ST_RELEASE: begin
				// Clocks stay gated until the released macro has settled
				if (cnt_reached(st_r.cnt, SETTLE_LAST)) begin
					st_nxt.state = ST_UNGATE;
					st_nxt.clock_gated = 1'b0;
				end else begin
					st_nxt.cnt = cnt_step(st_r.cnt);
				end
			end
			ST_UNGATE: begin
				st_nxt.state = ST_IDLE;
				st_nxt.sleep_active = 1'b0;
			end
			default: begin
				st_nxt.state = ST_IDLE;
			end
		endcase

		// Pad state, decided per pin from its own configuration bits
		for (int i = 0; i < NUM_PADS; i++) begin
			// Awake: pads follow the core with pulls off
			if (!st_r.sleep_active) begin
				st_nxt.drive.out[i] = core_out[i];
				st_nxt.drive.oe[i] = core_oe[i];
				st_nxt.drive.pull_en[i] = 1'b0;
				st_nxt.drive.pull_up[i] = 1'b0;
				st_nxt.core_in[i] = st_r.pad_level[i];
			end else begin
				st_nxt.drive.out[i] = 1'b0;
				st_nxt.drive.oe[i] = 1'b0;
				st_nxt.drive.pull_en[i] = st_r.cfg.pull_en[i];
				st_nxt.drive.pull_up[i] = st_r.cfg.pull_up[i];
				if (st_r.held_oe[i]) begin
					if (st_r.cfg.hold_en[i]) begin
						st_nxt.drive.pull_en[i] = 1'b1;
						st_nxt.drive.pull_up[i] = st_r.held_out[i];
					end
				end
				if (st_r.cfg.hold_en[i]) begin
					st_nxt.core_in[i] = st_r.held_in[i];
				end else begin
					st_nxt.core_in[i] = 1'b1;
				end
			end
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			if (is_cfg(st_r.waddr)) begin
				st_nxt.cfg = pad_cfg_type'(merge_bytes(st_r.cfg, st_r.wdata, st_r.wstrb));
				st_nxt.cfg.reserved = '0;
				st_nxt.bresp = RESP_OKAY;
			end else if (is_status(st_r.waddr)) begin
				st_nxt.bresp = RESP_OKAY;
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end
		st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

		// Read channel
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			stat.state = st_r.state;
			stat.sleep_active = st_r.sleep_active;
			stat.macro_en = st_r.macro_en;
			stat.clock_gated = st_r.clock_gated;
			stat.prepare_req = st_r.prepare_req;
			stat.pin_level = st_r.pin_level;
			if (is_cfg(s_axi_araddr)) begin
				st_nxt.rdata = st_r.cfg;
				st_nxt.rresp = RESP_OKAY;
			end else if (is_status(s_axi_araddr)) begin
				st_nxt.rdata = stat;
				st_nxt.rresp = RESP_OKAY;
			end else begin
				st_nxt.rdata = '0;
				st_nxt.rresp = RESP_SLVERR;
			end
		end
		st_nxt.arready = !st_nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Every output comes straight from the state register
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign prepare_req = st_r.prepare_req;
	assign clock_gate_en = st_r.clock_gated;
	assign low_power_entry_macro_en = st_r.macro_en;
	assign sleep_active = st_r.sleep_active;
	assign core_in = st_r.core_in;
	assign pad_drive = st_r.drive;

endmodule // sleep_entry_sequencer

// ---- sleep_entry_sequencer_properties.sv ----
`timescale 1ns/100ps
module sleep_seq_checker
	import sleep_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sleep control
	input wire logic sleep_request_pin,
	input wire logic prepare_req,
	input wire logic prepare_done,
	input wire logic clock_gate_en,
	input wire logic low_power_entry_macro_en,
	input wire logic sleep_active,
	// Write response
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	logic [3:0] hi_r;
	// Edges from a raw request to the first qualify count: three stages, filter, idle step
	localparam int SYNC_EDGES = 5;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles the raw request has stayed high
	always_ff @(posedge aclk) hi_r <= (!aresetn || !sleep_request_pin) ? 4'h0 : hi_r + {3'h0, hi_r != 4'hF};
	a_prep_qual: assert property ($rose(prepare_req) |-> hi_r >= SYNC_EDGES + QUALIFY_CYCLES)
		else $error("unqualified prepare");
	a_done_gate: assert property (prepare_req && prepare_done |=> !prepare_req &&
		(clock_gate_en || !$past(sleep_request_pin, 4))) else $error("no gating after done");
	a_gate_macro: assert property ($rose(clock_gate_en) |->
		!low_power_entry_macro_en [*2] ##1 low_power_entry_macro_en) else $error("macro timing");
	a_act_rise: assert property ($rose(sleep_active) |-> $past(low_power_entry_macro_en) && clock_gate_en)
		else $error("early sleep active");
	a_act_hold: assert property ($fell(sleep_active) |-> !$past(sleep_request_pin, 3))
		else $error("sleep active dropped early");
	a_exit_order: assert property ($fell(low_power_entry_macro_en) |->
		clock_gate_en [*2] ##1 (!clock_gate_en && sleep_active) ##1 !sleep_active) else $error("exit order");
	a_no_req: assert property (sleep_active |-> !prepare_req)
		else $error("prepare while asleep");
	a_resp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	c_enter: cover property ($rose(sleep_active));
	c_leave: cover property ($fell(sleep_active));
	c_abort: cover property ($fell(prepare_req) && !clock_gate_en);
endmodule // sleep_seq_checker
bind sleep_entry_sequencer sleep_seq_checker i_sleep_seq_checker (.aclk, .aresetn, .sleep_request_pin, .prepare_req,
	.prepare_done, .clock_gate_en, .low_power_entry_macro_en, .sleep_active, .s_axi_bvalid, .s_axi_bready);

// ---- sleep_seq_pkg.sv ----
package sleep_seq_pkg;

	// Pads under sleep control
	localparam int NUM_PADS = 8;

	// Request qualification length and clock gating settle time, in aclk cycles
	localparam int QUALIFY_CYCLES = 4;
	localparam int GATE_SETTLE_CYCLES = 2;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] QUALIFY_LAST = CNT_W'(QUALIFY_CYCLES - 1);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(GATE_SETTLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	// Register byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] PAD_CFG_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Fully encoded three-bit sequencer state
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_QUALIFY = 3'h1,
		ST_HOUSEKEEP = 3'h2,
		ST_GATE = 3'h3,
		ST_ENTER = 3'h4,
		ST_ASLEEP = 3'h5,
		ST_RELEASE = 3'h6,
		ST_UNGATE = 3'h7
	} seq_state_type;

	// Per-pin sleep configuration word
	typedef struct packed {
		logic [7:0] reserved;
		logic [NUM_PADS-1:0] pull_up;
		logic [NUM_PADS-1:0] pull_en;
		logic [NUM_PADS-1:0] hold_en;
	} pad_cfg_type;

	localparam pad_cfg_type PAD_CFG_RESET = '{default: '0};

	// Status word seen by software
	typedef struct packed {
		logic [23:0] reserved;
		logic pin_level;
		logic prepare_req;
		logic clock_gated;
		logic macro_en;
		logic sleep_active;
		seq_state_type state;
	} status_type;

	// Pad drive group towards the I/O ring
	typedef struct packed {
		logic [NUM_PADS-1:0] out;
		logic [NUM_PADS-1:0] oe;
		logic [NUM_PADS-1:0] pull_en;
		logic [NUM_PADS-1:0] pull_up;
	} pad_drive_type;

endpackage

// ---- tb_sleep_entry_sequencer.sv ----
`timescale 1ns/100ps
module tb_sleep_entry_sequencer;
	import sleep_seq_pkg::*;
	localparam logic [7:0] CFG_H = 8'h0F;
	localparam logic [7:0] CFG_P = 8'h3C;
	localparam logic [7:0] CFG_U = 8'h14;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic sleep_request_pin = 1'h0;
	logic prepare_req, prepare_done, clock_gate_en, low_power_entry_macro_en, sleep_active;
	logic [NUM_PADS-1:0] core_out = 8'hA3, core_oe = 8'h55, core_in, pad_in = 8'h5A;
	pad_drive_type pad_drive;
	logic [7:0] hk_delay = 8'h05;
	int fails = 0, compares = 0, cyc = 0;

	initial forever #10 aclk = ~aclk;

	sleep_entry_sequencer i_sleep_entry_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sleep_request_pin, .prepare_req, .prepare_done, .clock_gate_en,
		.low_power_entry_macro_en, .sleep_active, .core_out, .core_oe, .core_in, .pad_in, .pad_drive);
	housekeeping_model i_housekeeping_model (.aclk, .aresetn, .prepare_req, .delay(hk_delay), .prepare_done);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask

	task automatic wt(input logic v);
		do @(posedge aclk); while (sleep_active !== v);
	endtask

	// Pad controls and core view while asleep
	task automatic slp;
		logic [7:0] hm;
		hm = CFG_H & core_oe;
		chk({8'h00, pad_drive[23:0]}, {16'h0000, hm | (CFG_P & ~hm), (core_out & hm) | (CFG_U & ~hm)});
		chk({24'h0, core_in}, {24'h0, (pad_in & CFG_H) | ~CFG_H});
	endtask

	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			results;
		end
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk({28'h0, sleep_active, prepare_req, clock_gate_en, low_power_entry_macro_en}, 32'h0);
		chk(pad_drive, 32'h0);
		rd(PAD_CFG_ADDR, 32'h0, RESP_OKAY);
		wr(PAD_CFG_ADDR, {8'hFF, CFG_U, CFG_P, CFG_H}, RESP_OKAY);
		rd(PAD_CFG_ADDR, {8'h00, CFG_U, CFG_P, CFG_H}, RESP_OKAY);
		// Byte lane 1 alone: only the pull enables change
		s_axi_wstrb <= 4'h2;
		wr(PAD_CFG_ADDR, 32'h0000_0000, RESP_OKAY);
		rd(PAD_CFG_ADDR, {8'h00, CFG_U, 8'h00, CFG_H}, RESP_OKAY);
		wr(PAD_CFG_ADDR, {16'h0000, CFG_P, 8'h00}, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(PAD_CFG_ADDR, {8'h00, CFG_U, CFG_P, CFG_H}, RESP_OKAY);
		wr(4'h8, 32'h1, RESP_SLVERR);
		rd(4'hC, 32'h0, RESP_SLVERR);
		wr(STATUS_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
		// A short glitch must not start a sequence
		sleep_request_pin <= 1'h1;
		repeat (3) @(posedge aclk);
		sleep_request_pin <= 1'h0;
		repeat (12) @(posedge aclk);
		rd(STATUS_ADDR, 32'h0, RESP_OKAY);
		// Slow housekeeping first, then loopback with every pad an output
		for (int k = 0; k < 2; k++) begin
			hk_delay <= k ? 8'h00 : 8'h05;
			core_oe <= k ? 8'hFF : 8'h55;
			sleep_request_pin <= 1'h1; // Strong drive, no pull
			wt(1'h1);
			repeat (2) @(posedge aclk);
			slp;
			rd(STATUS_ADDR, 32'h0000_00BD, RESP_OKAY);
			pad_in <= ~pad_in;
			repeat (6) @(posedge aclk);
			chk({24'h0, core_in}, {24'h0, (~pad_in & CFG_H) | ~CFG_H});
			sleep_request_pin <= 1'h0;
			wt(1'h0);
			chk({30'h0, clock_gate_en, low_power_entry_macro_en}, 32'h0);
			repeat (5) @(posedge aclk);
			chk(pad_drive, {core_out, core_oe, 16'h0000});
			chk({24'h0, core_in}, {24'h0, pad_in});
		end
		// Request withdrawn during housekeeping
		hk_delay <= 8'h28;
		sleep_request_pin <= 1'h1;
		do @(posedge aclk); while (prepare_req !== 1'h1);
		sleep_request_pin <= 1'h0;
		repeat (10) @(posedge aclk);
		chk({30'h0, clock_gate_en, prepare_req}, 32'h0);
		rd(STATUS_ADDR, 32'h0, RESP_OKAY);
		results;
	end
endmodule // tb_sleep_entry_sequencer
